// file: rtl/cmt_ctrl.sv
`timescale 1ns/1ps
`include "cmt_map.svh"
module cmt_ctrl (
  input wire logic REF_CLK,
  input wire logic RST,
  input cmt_pkg::cmt_cp_req_t CP_REQ,
  output logic CP_STALL,
  output logic CP_RVALID,
  output logic [31:0] CP_RDATA,
  output cmt_pkg::cmt_cache_cmd_t CACHE_CMD,
  output logic CACHE_REQ,
  input wire logic CACHE_ACK,
  input wire logic LINEFILL_BUSY,
  input wire logic WB_EMPTY,
  output logic WB_DRAIN,
  output logic CORE_CLOCK_GATE,
  output logic LOW_POWER,
  input wire logic FAST_INTERRUPT_N,
  input wire logic NORMAL_INTERRUPT_N,
  input wire logic EXTERNAL_DEBUG_REQUEST,
  input wire logic DEBUG_REQ_BIT,
  input wire logic DEBUG_PERMIT,
  output logic WAKE_IRQ,
  output logic WAKE_DEBUG,
  input wire logic [4:0] DTCM_PHYS_SIZE,
  input wire logic [4:0] ITCM_PHYS_SIZE,
  output logic [31:0] DLOCK_WORD,
  output logic [31:0] ILOCK_WORD,
  input wire logic DATA_VALID,
  input wire logic DATA_WRITE,
  input wire logic [31:0] DATA_ADDR,
  input wire logic DTCM_ENABLE,
  input wire logic ITCM_ENABLE,
  input wire logic ITCM_LOAD_MODE,
  output logic DATA_TO_ITCM,
  output logic DATA_TO_DTCM,
  output logic [31:0] TCM_OFFSET
);
  import cmt_pkg::*;

  // command match on register, crm and opcode2
  function automatic logic is_cmd(input cmt_cp_req_t r, input logic [3:0] crn,
                                  input logic [3:0] crm, input logic [2:0] op2);
    is_cmd = r.valid && r.crn == crn && r.crm == crm && r.op2 == op2;
  endfunction

  // address mask of an area, bytes = 2^(code+9)
  function automatic logic [31:0] area_mask(input logic [4:0] code);
    logic [5:0] sh;
    sh = {1'b0, code} + `CMT_SIZE_SHIFT;
    if (code >= `CMT_SIZE_4GB) begin
      area_mask = 32'h00000000;
    end else begin
      area_mask = 32'hffffffff << sh;
    end
  endfunction

  // sequencer state and the held maintenance command
  cmt_state_t state_q, state_d;
  cmt_cache_cmd_t pend_q, pend_d;
  // lockdown words and region fields
  logic [31:0] dlock_q, ilock_q;
  logic [19:0] dbase_q;
  logic [4:0] dsize_q, isize_q;
  // physical size codes, captured once after reset
  logic [4:0] dphys_q, iphys_q;
  logic init_q;
  // decoded transfer kinds
  logic wr, rd, maint;
  logic wfi, drain;
  // wake causes while in standby
  logic wake_irq, wake_dbg;
  // index mask and area hits
  logic [12:0] idx_mask;
  logic d_hit, i_hit;

  // request qualification and wake sources
  assign wr = CP_REQ.valid && CP_REQ.write && state_q == ST_IDLE;
  assign rd = CP_REQ.valid && !CP_REQ.write && state_q == ST_IDLE;
  assign wfi = wr && (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C0, `CMT_OP2_4) ||
               is_cmd(CP_REQ, `CMT_CRN_TEST, `CMT_CRM_C8, `CMT_OP2_2)); // [RL8]
  assign drain = wr && is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C10, `CMT_OP2_4); // [RL7]
  assign wake_irq = !FAST_INTERRUPT_N || !NORMAL_INTERRUPT_N; // [RL10]
  assign wake_dbg = DEBUG_PERMIT && (EXTERNAL_DEBUG_REQUEST || DEBUG_REQ_BIT); // [RL11]
  assign idx_mask = 13'h1fff >> (`CMT_IDX_MAXMSB - `CMT_IDX_MSB); // [RL5]

  // maintenance decode into a cache command
  always_comb begin
    pend_d = pend_q;
    pend_d.kind = OP_NONE;
    pend_d.addr = CP_REQ.wdata;
    pend_d.seg = CP_REQ.wdata[`CMT_SEG_HI:`CMT_SEG_LO]; // [RL23]
    pend_d.idx = CP_REQ.wdata[`CMT_IDX_MAXMSB:`CMT_IDX_LO] & idx_mask; // [RL4]
    if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C5, `CMT_OP2_0)) begin
      pend_d.kind = OP_IC_ALL; // [RL1]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C5, `CMT_OP2_1)) begin
      pend_d.kind = OP_IC_ENTRY; // [RL1]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C13, `CMT_OP2_1)) begin
      pend_d.kind = OP_IC_PREFETCH; // [RL1]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C6, `CMT_OP2_0)) begin
      pend_d.kind = OP_DC_ALL; // [RL2]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C6, `CMT_OP2_1)) begin
      pend_d.kind = OP_DC_ENTRY; // [RL2]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C10, `CMT_OP2_1)) begin
      pend_d.kind = OP_DC_CLEAN; // [RL3]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C14, `CMT_OP2_1)) begin
      pend_d.kind = OP_DC_CLEAN_INV; // [RL3]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C10, `CMT_OP2_2)) begin
      pend_d.kind = OP_DC_CLEAN_IDX; // [RL4]
    end else if (is_cmd(CP_REQ, `CMT_CRN_CACHE, `CMT_CRM_C14, `CMT_OP2_2)) begin
      pend_d.kind = OP_DC_CLEAN_INV_IDX; // [RL4]
    end
  end
  assign maint = wr && pend_d.kind != OP_NONE;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (maint) begin
          state_d = LINEFILL_BUSY ? ST_FILL : ST_OP; // [RL6]
        end else if (drain) begin
          state_d = ST_DRAIN;
        end else if (wfi) begin
          state_d = ST_STBY;
        end
      end
      ST_FILL: begin
        if (!LINEFILL_BUSY) begin
          state_d = ST_OP; // [RL6]
        end
      end
      ST_OP: begin
        if (CACHE_ACK) begin
          state_d = ST_IDLE; // [RL24]
        end
      end
      ST_DRAIN: begin
        if (WB_EMPTY) begin
          state_d = ST_IDLE; // [RL7]
        end
      end
      ST_STBY: begin
        if (wake_irq || wake_dbg) begin
          state_d = ST_IDLE; // [RL9]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // held maintenance command
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pend_q <= '0;
    end else if (maint) begin
      pend_q <= pend_d;
    end
  end

  // cache command handshake, request held until ack
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CACHE_REQ <= 1'b0;
      CACHE_CMD <= '0;
    end else if (state_d == ST_OP && !(state_q == ST_OP && CACHE_ACK)) begin
      CACHE_REQ <= 1'b1; // [RL24]
      CACHE_CMD <= (state_q == ST_IDLE) ? pend_d : pend_q;
    end else begin
      CACHE_REQ <= 1'b0;
    end
  end

  // core stall, clock gate and low power
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CP_STALL <= 1'b0;
      CORE_CLOCK_GATE <= 1'b1;
      LOW_POWER <= 1'b0;
    end else begin
      CP_STALL <= state_d != ST_IDLE; // [RL24]
      CORE_CLOCK_GATE <= state_d != ST_STBY; // [RL8]
      LOW_POWER <= state_d == ST_STBY; // [RL8]
    end
  end

  // write buffer drain, also while in standby
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_DRAIN <= 1'b0;
    end else begin
      WB_DRAIN <= (state_d == ST_DRAIN || state_d == ST_STBY) && !WB_EMPTY; // [RL7] [RL13]
    end
  end

  // one-cycle wake cause toward the core
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WAKE_IRQ <= 1'b0;
      WAKE_DEBUG <= 1'b0;
    end else begin
      WAKE_IRQ <= state_q == ST_STBY && wake_irq; // [RL12]
      WAKE_DEBUG <= state_q == ST_STBY && wake_dbg; // [RL12]
    end
  end

  // lockdown words, load bit and segment kept
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dlock_q <= `CMT_RST_LOCK;
      ilock_q <= `CMT_RST_LOCK;
    end else if (wr && is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C0, `CMT_OP2_0)) begin
      dlock_q <= {CP_REQ.wdata[`CMT_LOCK_LOAD_BIT], 29'h0, CP_REQ.wdata[`CMT_LOCK_SEG_HI:0]}; // [RL14]
    end else if (wr && is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C0, `CMT_OP2_1)) begin
      ilock_q <= {CP_REQ.wdata[`CMT_LOCK_LOAD_BIT], 29'h0, CP_REQ.wdata[`CMT_LOCK_SEG_HI:0]}; // [RL14]
    end
  end
  assign DLOCK_WORD = dlock_q;
  assign ILOCK_WORD = ilock_q;

  // region registers; sizes and physical sizes loaded just after reset release
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      init_q <= 1'b1;
      dbase_q <= `CMT_RST_BASE; // [RL20]
      dsize_q <= `CMT_RST_SIZE;
      isize_q <= `CMT_RST_SIZE;
      dphys_q <= `CMT_RST_SIZE;
      iphys_q <= `CMT_RST_SIZE;
    end else if (init_q) begin
      init_q <= 1'b0;
      dsize_q <= DTCM_PHYS_SIZE; // [RL20]
      isize_q <= ITCM_PHYS_SIZE; // [RL20]
      dphys_q <= DTCM_PHYS_SIZE;
      iphys_q <= ITCM_PHYS_SIZE;
    end else if (wr && is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C1, `CMT_OP2_0)) begin
      dbase_q <= CP_REQ.wdata[`CMT_BASE_HI:`CMT_BASE_LO]; // [RL15] [RL16]
      dsize_q <= CP_REQ.wdata[`CMT_SIZE_HI:`CMT_SIZE_LO];
    end else if (wr && is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C1, `CMT_OP2_1)) begin
      isize_q <= CP_REQ.wdata[`CMT_SIZE_HI:`CMT_SIZE_LO]; // [RL15] [RL19]
    end
  end

  // read-back, one cycle after the request
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CP_RVALID <= 1'b0;
      CP_RDATA <= 32'h00000000;
    end else begin
      CP_RVALID <= rd;
      if (!rd) begin
        CP_RDATA <= 32'h00000000;
      end else if (is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C0, `CMT_OP2_0)) begin
        CP_RDATA <= dlock_q; // [RL14]
      end else if (is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C0, `CMT_OP2_1)) begin
        CP_RDATA <= ilock_q; // [RL14]
      end else if (is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C1, `CMT_OP2_0)) begin
        CP_RDATA <= {dbase_q, 6'h00, dsize_q, 1'b0}; // [RL16]
      end else if (is_cmd(CP_REQ, `CMT_CRN_LOCK, `CMT_CRM_C1, `CMT_OP2_1)) begin
        CP_RDATA <= {`CMT_RST_BASE, 6'h00, isize_q, 1'b0}; // [RL19]
      end else begin
        CP_RDATA <= 32'h00000000;
      end
    end
  end

  // area hit test against visible size
  assign d_hit = DTCM_ENABLE && ((DATA_ADDR & area_mask(dsize_q)) ==
                 ({dbase_q, 12'h000} & area_mask(dsize_q))); // [RL17]
  assign i_hit = ITCM_ENABLE && ((DATA_ADDR & area_mask(isize_q)) == 32'h00000000); // [RL19]

  // data access routing and aliased offset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DATA_TO_ITCM <= 1'b0;
      DATA_TO_DTCM <= 1'b0;
      TCM_OFFSET <= 32'h00000000;
    end else if (!DATA_VALID) begin
      DATA_TO_ITCM <= 1'b0;
      DATA_TO_DTCM <= 1'b0;
    end else if (i_hit && (!ITCM_LOAD_MODE || DATA_WRITE || !d_hit)) begin
      DATA_TO_ITCM <= 1'b1; // [RL22]
      DATA_TO_DTCM <= 1'b0;
      TCM_OFFSET <= DATA_ADDR & ~area_mask(iphys_q); // [RL18]
    end else begin
      DATA_TO_ITCM <= 1'b0;
      DATA_TO_DTCM <= d_hit; // [RL22]
      TCM_OFFSET <= DATA_ADDR & ~area_mask(dphys_q); // [RL18]
    end
  end
endmodule

// file: rtl/cmt_map.svh
// Notes on behaviour
// [RL1] c5 flushes instruction cache; c13 prefetches line
// [RL2] c6 flushes data cache, whole or entry
// [RL3] c10/c14 opcode2 1: clean, clean-invalidate address
// [RL4] opcode2 2: clean by segment and index
// [RL5] index width follows implemented cache size
// [RL6] running line fetch finishes before maintenance
// [RL7] drain command stalls until write buffer empty
// [RL8] standby commands gate core clock, low power
// [RL9] standby ends on interrupt or debug request
// [RL10] wake ignores status word interrupt disables
// [RL11] debug wake only while debug is permitted
// [RL12] core takes interrupt or debug after wake
// [RL13] write buffer keeps draining during standby
// [RL14] two lockdown words: load bit, segment
// [RL15] data and instruction region registers readable, writable
// [RL16] region: base 31:12, size 5:1, bit0 zero
// [RL17] size code 3 is 4KB, doubling to 4GB
// [RL18] oversized area aliases physical memory
// [RL19] instruction region base fixed, reads zero
// [RL20] reset clears bases, sizes from size register
// [RL21] software programs data region before enabling
// [RL22] overlap: data goes to instruction memory; with ITCM_LOAD_MODE set, reads go to data memory
// [RL23] segment is address bits 31 and 30
// [RL24] transfer stalls until maintenance completes
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH
`define CMT_CRN_CACHE 4'h7
`define CMT_CRN_LOCK 4'h9
`define CMT_CRN_TEST 4'hf
`define CMT_CRM_C0 4'h0
`define CMT_CRM_C1 4'h1
`define CMT_CRM_C5 4'h5
`define CMT_CRM_C6 4'h6
`define CMT_CRM_C8 4'h8
`define CMT_CRM_C10 4'ha
`define CMT_CRM_C13 4'hd
`define CMT_CRM_C14 4'he
`define CMT_OP2_0 3'h0
`define CMT_OP2_1 3'h1
`define CMT_OP2_2 3'h2
`define CMT_OP2_4 3'h4
`define CMT_LOCK_LOAD_BIT 31
`define CMT_LOCK_SEG_HI 1
`define CMT_SEG_HI 31
`define CMT_SEG_LO 30
`define CMT_IDX_LO 5
`define CMT_IDX_MAXMSB 17
`define CMT_CACHE_LOG2KB 2
`define CMT_IDX_MSB (7 + `CMT_CACHE_LOG2KB)
`define CMT_BASE_HI 31
`define CMT_BASE_LO 12
`define CMT_SIZE_HI 5
`define CMT_SIZE_LO 1
`define CMT_SIZE_SHIFT 6'd9
`define CMT_SIZE_4GB 5'h17
`define CMT_RST_BASE 20'h00000
`define CMT_RST_SIZE 5'h03
`define CMT_RST_LOCK 32'h00000000
`endif

// file: rtl/cmt_pkg.sv
package cmt_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FILL = 5'b00010,
    ST_OP = 5'b00100,
    ST_DRAIN = 5'b01000,
    ST_STBY = 5'b10000
  } cmt_state_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_IC_ALL = 4'h1,
    OP_IC_ENTRY = 4'h2,
    OP_IC_PREFETCH = 4'h3,
    OP_DC_ALL = 4'h4,
    OP_DC_ENTRY = 4'h5,
    OP_DC_CLEAN = 4'h6,
    OP_DC_CLEAN_INV = 4'h7,
    OP_DC_CLEAN_IDX = 4'h8,
    OP_DC_CLEAN_INV_IDX = 4'h9
  } cmt_op_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } cmt_cp_req_t;
  typedef struct packed {
    cmt_op_t kind;
    logic [1:0] seg;
    logic [12:0] idx;
    logic [31:0] addr;
  } cmt_cache_cmd_t;
endpackage

// file: tb/cmt_cache_model.sv
`timescale 1ns/1ps
module cmt_cache_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  output logic ack,
  input wire logic drain,
  input wire logic fill,
  output logic empty
);
  logic [2:0] wait_q;
  logic [2:0] cnt_q;
  // cache arrays answer a held request on its fourth cycle, one-cycle ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 3'h0;
      ack <= 1'b0;
    end else begin
      ack <= req && !ack && wait_q == 3'h2;
      wait_q <= (req && !ack) ? wait_q + 3'h1 : 3'h0;
    end
  end
  // write buffer loses one entry per cycle while asked to drain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 3'h0;
    else if (fill) cnt_q <= 3'h5;
    else if (drain && cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign empty = (cnt_q == 3'h0);
endmodule

// file: tb/cmt_ctrl_sva.sv
`timescale 1ns/1ps
module cmt_ctrl_sva (
  input logic REF_CLK,
  input logic RST,
  input cmt_pkg::cmt_cp_req_t CP_REQ,
  input logic CP_STALL,
  input logic CP_RVALID,
  input logic CACHE_REQ,
  input logic CACHE_ACK,
  input logic LINEFILL_BUSY,
  input logic WB_EMPTY,
  input logic WB_DRAIN,
  input logic CORE_CLOCK_GATE,
  input logic LOW_POWER,
  input logic FAST_INTERRUPT_N,
  input logic NORMAL_INTERRUPT_N,
  input logic EXTERNAL_DEBUG_REQUEST,
  input logic DEBUG_PERMIT,
  input logic WAKE_IRQ,
  input logic WAKE_DEBUG
);
  import cmt_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // a transfer is taken when the port is not stalled; slice is crn, crm, op2
  wire take = CP_REQ.valid && !CP_STALL;
  sequence s_stby_cmd;
    take && CP_REQ.write && (CP_REQ[42:32] == {4'h7, 4'h0, 3'h4} || CP_REQ[42:32] == {4'hf, 4'h8, 3'h2});
  endsequence
  sequence s_asleep;
    LOW_POWER && !CORE_CLOCK_GATE && CP_STALL;
  endsequence
  AST_STBY_ENTER: assert property (s_stby_cmd |=> s_asleep)
    else $error("standby not entered");
  AST_STBY_HOLD: assert property (
    LOW_POWER && FAST_INTERRUPT_N && NORMAL_INTERRUPT_N && !DEBUG_PERMIT |=> s_asleep)
    else $error("standby left without cause");
  AST_WAKE_IRQ: assert property (
    LOW_POWER && !(FAST_INTERRUPT_N && NORMAL_INTERRUPT_N) |=> WAKE_IRQ && CORE_CLOCK_GATE && !CP_STALL ##1 !WAKE_IRQ)
    else $error("interrupt wake wrong");
  AST_WAKE_DBG: assert property (
    LOW_POWER && DEBUG_PERMIT && EXTERNAL_DEBUG_REQUEST |=> WAKE_DEBUG && !LOW_POWER)
    else $error("debug wake wrong");
  AST_FILL_FIRST: assert property ($rose(CACHE_REQ) |-> !$past(LINEFILL_BUSY))
    else $error("maintenance during line fetch");
  AST_REQ_HOLD: assert property (CACHE_REQ && !CACHE_ACK |=> CACHE_REQ && CP_STALL)
    else $error("maintenance dropped early");
  AST_READ: assert property (take && !CP_REQ.write && CP_REQ.crn == 4'h9 |=> CP_RVALID ##1 !CP_RVALID)
    else $error("read answer wrong");
  AST_WB_STBY: assert property (
    LOW_POWER && $past(LOW_POWER) && !WB_EMPTY && !$past(WB_EMPTY) |-> WB_DRAIN)
    else $error("no drain in standby");
endmodule
bind cmt_ctrl cmt_ctrl_sva i_cmt_ctrl_sva (.REF_CLK(REF_CLK), .RST(RST), .CP_REQ(CP_REQ), .CP_STALL(CP_STALL),
  .CP_RVALID(CP_RVALID), .CACHE_REQ(CACHE_REQ), .CACHE_ACK(CACHE_ACK), .LINEFILL_BUSY(LINEFILL_BUSY),
  .WB_EMPTY(WB_EMPTY), .WB_DRAIN(WB_DRAIN), .CORE_CLOCK_GATE(CORE_CLOCK_GATE), .LOW_POWER(LOW_POWER),
  .FAST_INTERRUPT_N(FAST_INTERRUPT_N), .NORMAL_INTERRUPT_N(NORMAL_INTERRUPT_N),
  .EXTERNAL_DEBUG_REQUEST(EXTERNAL_DEBUG_REQUEST), .DEBUG_PERMIT(DEBUG_PERMIT), .WAKE_IRQ(WAKE_IRQ),
  .WAKE_DEBUG(WAKE_DEBUG));

// file: tb/cache_maint_tcm_region_ctrl_tb.sv
`timescale 1ns/1ps
module cache_maint_tcm_region_ctrl_tb;
  import cmt_pkg::*;
  logic clk = 0, rst = 1, stall, rv, creq, cack, busy = 0, wb_mt, drain, gate, lp, wk_i, wk_d, fill = 0;
  logic fiq_n = 1, irq_n = 1, xdbg = 0, dbit = 0, permit = 0, dv = 0, dw = 0, en = 0, lm = 0, to_i, to_d;
  logic [31:0] rdata, dlock, ilock, da = 0, ofs;
  cmt_cp_req_t req = '0;
  cmt_cache_cmd_t cmd;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  // core clock
  initial forever #12.5 clk = ~clk;
  cmt_ctrl i_cmt_ctrl (.REF_CLK(clk), .RST(rst), .CP_REQ(req), .CP_STALL(stall), .CP_RVALID(rv),
    .CP_RDATA(rdata), .CACHE_CMD(cmd), .CACHE_REQ(creq), .CACHE_ACK(cack), .LINEFILL_BUSY(busy),
    .WB_EMPTY(wb_mt), .WB_DRAIN(drain), .CORE_CLOCK_GATE(gate), .LOW_POWER(lp), .FAST_INTERRUPT_N(fiq_n),
    .NORMAL_INTERRUPT_N(irq_n), .EXTERNAL_DEBUG_REQUEST(xdbg), .DEBUG_REQ_BIT(dbit), .DEBUG_PERMIT(permit),
    .WAKE_IRQ(wk_i), .WAKE_DEBUG(wk_d), .DTCM_PHYS_SIZE(5'h04), .ITCM_PHYS_SIZE(5'h04), .DLOCK_WORD(dlock),
    .ILOCK_WORD(ilock), .DATA_VALID(dv), .DATA_WRITE(dw), .DATA_ADDR(da), .DTCM_ENABLE(en),
    .ITCM_ENABLE(en), .ITCM_LOAD_MODE(lm), .DATA_TO_ITCM(to_i), .DATA_TO_DTCM(to_d), .TCM_OFFSET(ofs));
  cmt_cache_model i_cmt_cache_model (.clk(clk), .rst(rst), .req(creq), .ack(cack), .drain(drain),
    .fill(fill), .empty(wb_mt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer: valid for one cycle, returns in the cycle after it is taken
  task automatic cp(input logic wr, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
    input logic [31:0] wd);
    @(negedge clk);
    req = '{1'b1, wr, crn, crm, op2, wd};
    @(negedge clk);
    req.valid = 1'b0;
  endtask
  task automatic rd(input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] exp);
    cp(1'b0, 4'h9, crm, op2, 32'h0);
    chk(rv, 1'b1, "rvalid");
    chk(rdata, exp, "read");
  endtask
  task automatic idle;
    repeat (60) if (stall) @(negedge clk);
    chk(stall, 1'b0, "stall");
  endtask
  task automatic t_regs;
    rd(4'h1, 3'h0, 32'h8);
    rd(4'h1, 3'h1, 32'h8);
    cp(1'b1, 4'h9, 4'h1, 3'h0, 32'h0000400b);
    rd(4'h1, 3'h0, 32'h0000400a);
    cp(1'b1, 4'h9, 4'h1, 3'h1, 32'h0000000a);
    rd(4'h1, 3'h1, 32'h0000000a);
    cp(1'b1, 4'h9, 4'h0, 3'h0, 32'hffffffff);
    rd(4'h0, 3'h0, 32'h80000003);
    chk(dlock, 32'h80000003, "dlock");
    cp(1'b1, 4'h9, 4'h0, 3'h1, 32'h80000002);
    rd(4'h0, 3'h1, 32'h80000002);
    chk(ilock, 32'h80000002, "ilock");
  endtask
  task automatic acc(input logic wr, input logic load, input logic ei, input logic ed);
    @(negedge clk);
    {dv, dw, lm, da} = {1'b1, wr, load, 32'h00003004};
    @(negedge clk);
    dv = 1'b0;
    chk(to_i, ei, "to itcm");
    chk(to_d, ed, "to dtcm");
    chk(ofs, 32'h1004, "offset");
  endtask
  task automatic t_route;
    en = 1'b1;
    acc(1'b0, 1'b0, 1'b1, 1'b0);
    en = 1'b0;
    cp(1'b1, 4'h9, 4'h1, 3'h0, 32'h0000000a);
    en = 1'b1;
    acc(1'b0, 1'b0, 1'b1, 1'b0);
    acc(1'b0, 1'b1, 1'b0, 1'b1);
    acc(1'b1, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic t_maint;
    logic [3:0] crms [9] = '{4'h5, 4'h5, 4'hd, 4'h6, 4'h6, 4'ha, 4'he, 4'ha, 4'he};
    logic [2:0] ops [9] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
    for (int i = 0; i < 9; i++) begin
      busy = (i == 3);
      cp(1'b1, 4'h7, crms[i], ops[i], 32'hc00007e4);
      if (busy) begin
        repeat (3) @(negedge clk);
        chk(creq, 1'b0, "req in fill");
        busy = 1'b0;
        @(negedge clk);
      end
      chk(creq, 1'b1, "req raised");
      chk(cmd.kind, i + 1, "kind");
      if (ops[i] != 3'h0) chk(cmd.addr, 32'hc00007e4, "addr");
      if (ops[i] == 3'h2) chk({cmd.seg, cmd.idx}, {2'h3, 13'h1f}, "seg idx");
      chk(stall, 1'b1, "busy");
      idle();
    end
  endtask
  task automatic t_drain;
    fill = 1'b1;
    cp(1'b1, 4'h7, 4'ha, 3'h4, 32'h0);
    fill = 1'b0;
    chk(stall, 1'b1, "drain stall");
    chk(drain, 1'b1, "drain asked");
    idle();
    chk(wb_mt, 1'b1, "wb empty");
  endtask
  task automatic t_stby;
    for (int c = 0; c < 4; c++) begin
      fill = 1'b1;
      if (c[0]) cp(1'b1, 4'hf, 4'h8, 3'h2, 32'h0);
      else cp(1'b1, 4'h7, 4'h0, 3'h4, 32'h0);
      fill = 1'b0;
      chk({lp, gate}, 2'b10, "standby");
      repeat (8) @(negedge clk);
      chk({lp, wb_mt}, 2'b11, "asleep drained");
      if (c == 3) begin
        xdbg = 1'b1;
        repeat (3) @(negedge clk);
        chk(lp, 1'b1, "no debug wake");
      end
      {fiq_n, irq_n, xdbg, dbit, permit} = {c != 0, c != 1, c == 2, c == 3, c > 1};
      @(negedge clk);
      chk({lp, gate, stall}, 3'b010, "awake");
      chk({wk_i, wk_d}, {c < 2, c > 1}, "cause");
      {fiq_n, irq_n, xdbg, dbit, permit} = 5'b11000;
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_regs();
    t_route();
    t_maint();
    t_drain();
    t_stby();
    report_and_stop();
  end
endmodule
